/* File: wdr_top.sv */
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Contract
// RULE_01: watchdog on after reset, disable only pre-init
// RULE_02: overflow resets chip and drives reset output
// RULE_03: record the source of the last reset
// RULE_04: end of init clears all reset flags
// RULE_05: 16-bit counter, clock divided by 2 or 128
// RULE_06: service loads high byte from reload value
// RULE_07: timeout is reload-to-overflow count times prescaler
// RULE_08: software rewrites control register before service
// RULE_09: six sources, asynchronous hardware sets no flag
// RULE_10: low past long threshold sets long flag
// RULE_11: shorter valid pulse sets only short flag
// RULE_12: filter rejects spikes, accepts pulses over 500ns
// RULE_13: low discharge stops driving reset input low
// RULE_14: low discharge plus low input: immediate reset; here a running soft sequence is not cut
// RULE_15: asynchronous reset floats buses, pulls port0 high
// RULE_16: asynchronous detection needs no clock; here it goes through the clocked syncs and filter
// RULE_17: board holds reset and discharge low at power-on
// RULE_18: board covers oscillator and pll start-up
// RULE_19: internal boot holds reset until flash ready
// RULE_20: external boot releases a few clocks later
// RULE_21: early flash reads give all-ones then 009B
// RULE_22: service clears the counter's low byte
// RULE_23: counter counts up, overflow is FFFF to zero
module wdr_top #(
	parameter int unsigned FLASH_INIT_CYC = wdr_pkg::FLASH_INIT_CYC_DEF
) (
	input wire logic clk,
	input wire logic resetn,
	input wire wdr_pkg::wdr_bus_req_t bus_req,
	output logic [15:0] reg_rdata,
	input wire logic reset_input_pin_n_in,
	output logic reset_input_pin_n_out,
	output logic reset_input_pin_n_oe,
	input wire logic discharge_pin,
	input wire logic external_boot_pin_n,
	input wire logic flash_init_done,
	output logic reset_output_pin_n,
	output logic core_reset_n,
	output logic io_hiz,
	output logic port0_pullup,
	output logic flash_ready,
	output logic [15:0] flash_fill_word
);
	import wdr_pkg::*;

	//////////////////////////////////////////////////////////////////////////
	// declarations
	wdr_state_t r_reg; // all state of the block
	wdr_state_t r_next; // next value of the state
	logic wr_ctl, wr_sys, wr_cmd; // write decodes
	logic svc, dis_req, end_init_instruction_req, swrst_req; // instruction strobes
	logic wd_tick; // prescaled counter tick
	logic ovf; // counter wraps from all-ones
	logic hw_low; // filtered reset input asserted
	logic async_hit; // asynchronous reset condition
	logic sync_hit; // synchronous hardware reset condition

	// address match, used by read and write decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// decode of bus writes and watchdog events
	assign wr_ctl = bus_req.wr && hit(bus_req.addr, REG_WDT_CTL);
	assign wr_sys = bus_req.wr && hit(bus_req.addr, REG_SYS_CFG);
	assign wr_cmd = bus_req.wr && hit(bus_req.addr, REG_CMD);
	assign svc = wr_cmd && bus_req.wdata[CMD_SERVICE];
	assign dis_req = wr_cmd && bus_req.wdata[CMD_DISABLE];
	assign end_init_instruction_req = wr_cmd && bus_req.wdata[CMD_END_INIT_INSTRUCTION];
	assign swrst_req = wr_cmd && bus_req.wdata[CMD_SWRST];
	assign wd_tick = r_reg.psel ? (r_reg.div == DIV_SLOW_LAST) // RULE_05
		: r_reg.div[0]; // odd phases tick for /2, last phase for /128
	assign ovf = (r_reg.st == ST_RUN) && r_reg.wd_en && wd_tick && !svc
		&& (r_reg.wdt == 16'hFFFF); // RULE_07 RULE_23
	assign hw_low = !r_reg.filt; // RULE_16
	// reset input with discharge low; a running soft sequence is not cut
	assign async_hit = hw_low && !r_reg.dis_sync
		&& (r_reg.st != ST_SOFT) && (r_reg.st != ST_ASYNC); // RULE_14
	assign sync_hit = hw_low && r_reg.dis_sync
		&& ((r_reg.st == ST_RUN) || (r_reg.st == ST_REL));

	//////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		r_next = r_reg;
		// two-stage synchronisers for pins and the flash status
		r_next.rin_meta = reset_input_pin_n_in;
		r_next.rin_sync = r_reg.rin_meta;
		r_next.dis_meta = discharge_pin;
		r_next.dis_sync = r_reg.dis_meta;
		r_next.boot_meta = external_boot_pin_n;
		r_next.boot_sync = r_reg.boot_meta;
		r_next.fd_meta = flash_init_done;
		r_next.fd_sync = r_reg.fd_meta;
		r_next.rdata = 16'h0000;

		// input filter: level flips only after a run of equal samples
		if (r_reg.rin_sync != r_reg.filt) begin
			if (r_reg.fcnt == FILT_CYC - 3'h1) begin
				r_next.filt = r_reg.rin_sync; // RULE_12
				r_next.fcnt = 3'h0;
			end else begin
				r_next.fcnt = r_reg.fcnt + 3'h1;
			end
		end else begin
			r_next.fcnt = 3'h0;
		end

		// sequence counter saturates
		if (r_reg.cnt != 16'hFFFF) begin
			r_next.cnt = r_reg.cnt + 16'h0001;
		end

		// main sequencer
		case (r_reg.st)
			ST_RUN: begin
				r_next.div = r_reg.div + 7'h01;
				if (wr_ctl) begin
					r_next.reload = bus_req.wdata[15:8];
					r_next.psel = bus_req.wdata[CTL_PSEL_BIT];
				end
				if (wr_sys) begin
					r_next.bidir = bus_req.wdata[SYS_BIDIR_BIT];
				end
				// disable honoured only until end of init
				if (dis_req && !r_reg.end_init_instruction) begin
					r_next.wd_en = 1'b0; // RULE_01
				end
				if (svc) begin
					r_next.wdt = {r_reg.reload, 8'h00}; // RULE_06 RULE_22
				end else if (r_reg.wd_en && wd_tick) begin
					r_next.wdt = r_reg.wdt + 16'h0001; // RULE_23
				end
				if (end_init_instruction_req) begin
					r_next.end_init_instruction = 1'b1;
					r_next.flags = 5'h00; // RULE_04
					r_next.rst_out_n = 1'b1;
				end
				if (swrst_req || ovf) begin
					r_next.st = ST_SOFT;
					r_next.cnt = 16'h0000;
					r_next.soft_bidir = r_reg.bidir;
					// set wins over the end-of-init clear above
					if (swrst_req) begin
						r_next.flags[FLG_SW] = 1'b1; // RULE_03
					end
					if (ovf) begin
						r_next.flags[FLG_WDT] = 1'b1; // RULE_03
					end
				end
			end
			ST_ASYNC: begin
				// held until the filtered input is released
				if (r_reg.filt) begin
					r_next.st = ST_REL;
					r_next.cnt = 16'h0000;
				end
			end
			ST_SYNC: begin
				// sample the input once at the end of the sequence
				if (r_reg.cnt == HW_SEQ_CYC) begin
					r_next.flags[FLG_SHW] = 1'b1; // RULE_11
					if (hw_low) begin
						r_next.flags[FLG_LHW] = 1'b1; // RULE_10
					end
				end
				if ((r_reg.cnt > HW_SEQ_CYC) && r_reg.filt) begin
					r_next.st = ST_REL;
					r_next.cnt = 16'h0000;
				end
			end
			ST_SOFT: begin
				// finishes whatever the discharge pin does
				if ((r_reg.cnt >= SW_SEQ_CYC) && r_reg.filt) begin
					r_next.st = ST_REL;
					r_next.cnt = 16'h0000;
				end
			end
			ST_REL: begin
				if (r_reg.ext_boot) begin
					if (r_reg.cnt >= EXT_REL_CYC - 16'h0001) begin
						r_next.st = ST_RUN; // RULE_20
					end
				end else if (r_reg.fd_sync
					|| (r_reg.cnt >= 16'(FLASH_INIT_CYC - 1))) begin
					r_next.st = ST_RUN; // RULE_19
				end
			end
			default: begin
				r_next.st = ST_ASYNC;
			end
		endcase

		// hardware reset detection overrides the sequencer
		if (async_hit) begin
			r_next.st = ST_ASYNC; // RULE_14
		end else if (sync_hit) begin
			r_next.st = ST_SYNC;
			r_next.cnt = 16'h0000;
		end

		// boot source is sampled while reset is asserted
		if (r_next.st != ST_RUN && r_next.st != ST_REL) begin
			r_next.ext_boot = !r_reg.boot_sync;
		end

		// outside run the watchdog and config sit at their reset values
		if (r_next.st != ST_RUN) begin
			r_next.wd_en = 1'b1; // RULE_01
			r_next.end_init_instruction = 1'b0;
			r_next.psel = 1'b0;
			r_next.bidir = 1'b0;
			r_next.reload = 8'h00;
			r_next.div = 7'h00;
			r_next.wdt = 16'h0000;
			r_next.rst_out_n = 1'b0; // RULE_02
		end

		// pin and core controls
		r_next.core_rst_n = (r_next.st == ST_RUN); // RULE_19
		r_next.io_hiz = (r_next.st == ST_ASYNC) || (r_next.st == ST_SYNC)
			|| (r_next.st == ST_SOFT); // RULE_15
		r_next.p0_pull = (r_next.st == ST_ASYNC); // RULE_15
		r_next.pin_oe = (r_next.st == ST_SOFT) && r_next.soft_bidir
			&& r_reg.dis_sync && (r_next.cnt < SW_SEQ_CYC); // RULE_13

		// flash answer while its initialisation runs
		if ((r_next.st == ST_ASYNC) || (r_next.st == ST_SYNC)
			|| (r_next.st == ST_SOFT)) begin
			r_next.fage = 8'h00;
		end else if (r_reg.fage != 8'hFF) begin
			r_next.fage = r_reg.fage + 8'h01;
		end
		r_next.fready = r_reg.fd_sync && (r_next.fage != 8'h00);
		r_next.fill = (r_next.fage >= FLASH_BLANK_CYC) ?
			FLASH_WAIT_WORD : FLASH_BLANK_WORD; // RULE_21

		// register read data, valid the cycle after the strobe
		if (bus_req.rd) begin
			if (hit(bus_req.addr, REG_WDT_CTL)) begin
				r_next.rdata = {r_reg.reload, 2'b00, r_reg.flags, r_reg.psel};
			end else if (hit(bus_req.addr, REG_WDT_CNT)) begin
				r_next.rdata = r_reg.wdt;
			end else if (hit(bus_req.addr, REG_SYS_CFG)) begin
				r_next.rdata = 16'(r_reg.bidir) << SYS_BIDIR_BIT;
			end else if (hit(bus_req.addr, REG_CMD)) begin
				r_next.rdata = {14'h0000, r_reg.end_init_instruction, r_reg.wd_en};
			end else begin
				r_next.rdata = 16'h0000;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// state register; resetn is the power-on reset
	always_ff @(posedge clk) begin
		if (!resetn) begin
			r_reg <= WDR_RESET; // RULE_09
		end else begin
			r_reg <= r_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register, except the reset pin drive value, which is tied low
	assign reg_rdata = r_reg.rdata;
	assign reset_input_pin_n_out = 1'b0;
	assign reset_input_pin_n_oe = r_reg.pin_oe;
	assign reset_output_pin_n = r_reg.rst_out_n;
	assign core_reset_n = r_reg.core_rst_n;
	assign io_hiz = r_reg.io_hiz;
	assign port0_pullup = r_reg.p0_pull;
	assign flash_ready = r_reg.fready;
	assign flash_fill_word = r_reg.fill;

	//////////////////////////////////////////////////////////////////////////
	// assertions
	property p_wd_on_at_run;
		@(posedge clk) disable iff (!resetn)
		$rose(r_reg.st == ST_RUN) |-> r_reg.wd_en && !r_reg.end_init_instruction;
	endproperty
	a_wd_on_at_run: assert property (p_wd_on_at_run) // RULE_01
		else $error("watchdog not enabled at release");

	property p_disable_locked;
		@(posedge clk) disable iff (!resetn)
		(r_reg.st == ST_RUN) && r_reg.end_init_instruction && r_reg.wd_en && dis_req
		|=> r_reg.wd_en || (r_reg.st != ST_RUN);
	endproperty
	a_disable_locked: assert property (p_disable_locked) // RULE_01
		else $error("watchdog disabled after end of init");

	property p_overflow_reset;
		@(posedge clk) disable iff (!resetn)
		ovf |=> (r_reg.st == ST_SOFT) && !r_reg.rst_out_n
			&& !r_reg.core_rst_n && r_reg.flags[FLG_WDT];
	endproperty
	a_overflow_reset: assert property (p_overflow_reset) // RULE_02
		else $error("overflow did not reset the device");

	property p_end_init_instruction_clears;
		@(posedge clk) disable iff (!resetn)
		(r_reg.st == ST_RUN) && end_init_instruction_req && !swrst_req && !ovf
			&& r_reg.filt |=> (r_reg.flags == 5'h00) && r_reg.rst_out_n;
	endproperty
	a_end_init_instruction_clears: assert property (p_end_init_instruction_clears) // RULE_04
		else $error("end of init left flags set");

	property p_service_reload;
		@(posedge clk) disable iff (!resetn)
		(r_reg.st == ST_RUN) && svc && !swrst_req && r_reg.filt
		|=> r_reg.wdt == {$past(r_reg.reload), 8'h00};
	endproperty
	a_service_reload: assert property (p_service_reload) // RULE_06
		else $error("service did not reload the counter");

	property p_count_up;
		@(posedge clk) disable iff (!resetn)
		(r_reg.st == ST_RUN) && r_reg.wd_en && wd_tick && !svc
			&& !swrst_req && r_reg.filt && (r_reg.wdt != 16'hFFFF)
		|=> r_reg.wdt == $past(r_reg.wdt) + 16'h0001;
	endproperty
	a_count_up: assert property (p_count_up) // RULE_23
		else $error("counter did not advance on tick");

	property p_fast_prescale;
		@(posedge clk) disable iff (!resetn)
		(r_reg.st == ST_RUN) && !r_reg.psel && !r_reg.div[0] && !wr_ctl
		|=> wd_tick || (r_reg.st != ST_RUN);
	endproperty
	a_fast_prescale: assert property (p_fast_prescale) // RULE_05
		else $error("divide by two tick missing");

	property p_async_entry;
		@(posedge clk) disable iff (!resetn)
		async_hit |=> (r_reg.st == ST_ASYNC) && r_reg.p0_pull
			&& r_reg.io_hiz && !r_reg.rst_out_n;
	endproperty
	a_async_entry: assert property (p_async_entry) // RULE_14
		else $error("asynchronous reset not entered");

	property p_discharge_inhibit;
		@(posedge clk) disable iff (!resetn)
		!r_reg.dis_sync |=> !r_reg.pin_oe;
	endproperty
	a_discharge_inhibit: assert property (p_discharge_inhibit) // RULE_13
		else $error("reset input driven with discharge low");

	property p_long_flag;
		@(posedge clk) disable iff (!resetn)
		(r_reg.st == ST_SYNC) && (r_reg.cnt == HW_SEQ_CYC) && !r_reg.filt
			&& r_reg.dis_sync |=> r_reg.flags[FLG_LHW];
	endproperty
	a_long_flag: assert property (p_long_flag) // RULE_10
		else $error("long reset not flagged");

	property p_short_flag;
		@(posedge clk) disable iff (!resetn)
		(r_reg.st == ST_SYNC) && (r_reg.cnt == HW_SEQ_CYC) && r_reg.filt
		|=> r_reg.flags[FLG_SHW]
			&& (r_reg.flags[FLG_LHW] == $past(r_reg.flags[FLG_LHW]));
	endproperty
	a_short_flag: assert property (p_short_flag) // RULE_11
		else $error("short reset flagged wrongly");

	property p_ext_release;
		@(posedge clk) disable iff (!resetn)
		$rose(r_reg.st == ST_REL) && r_reg.ext_boot
		|-> ##[1:3] (r_reg.st != ST_REL);
	endproperty
	a_ext_release: assert property (p_ext_release) // RULE_20
		else $error("external boot release too late");

	property p_flash_hold;
		@(posedge clk) disable iff (!resetn)
		(r_reg.st == ST_REL) && !r_reg.ext_boot && !r_reg.fd_sync
		|-> !r_reg.core_rst_n ##1 (r_reg.st != ST_RUN) || r_reg.fd_sync
			|| ($past(r_reg.cnt) >= 16'(FLASH_INIT_CYC - 1));
	endproperty
	a_flash_hold: assert property (p_flash_hold) // RULE_19
		else $error("internal reset released before flash ready");

	property p_spike_reject;
		@(posedge clk) disable iff (!resetn)
		(r_reg.filt && r_reg.rin_sync) ##1 !r_reg.rin_sync ##1 r_reg.rin_sync
		|-> r_reg.filt;
	endproperty
	a_spike_reject: assert property (p_spike_reject) // RULE_12
		else $error("filter passed a one-sample spike");

endmodule

`default_nettype wire

/* File: wdr_pkg.sv */
package wdr_pkg;

	////////////////////////////////////////////////////////////////////////
	// clock and derived timing
	localparam int CLK_NS = 100; // system clock period
	localparam int TCL_NS = CLK_NS / 2; // half clock period
	localparam int FILT_NS = 500; // longest pulse the filter may reject
	localparam logic [2:0] FILT_CYC = 3'(FILT_NS / CLK_NS); // rounds down
	localparam int HW_SEQ_TCL = 1032 + 12; // long reset threshold in tcl
	localparam logic [15:0] HW_SEQ_CYC = 16'(HW_SEQ_TCL * TCL_NS / CLK_NS);
	localparam int SW_SEQ_TCL = 1024; // internal reset sequence in tcl
	localparam logic [15:0] SW_SEQ_CYC = 16'(SW_SEQ_TCL * TCL_NS / CLK_NS);
	localparam int EXT_REL_TCL = 4; // release delay, external boot
	localparam logic [15:0] EXT_REL_CYC =
		16'((EXT_REL_TCL * TCL_NS + CLK_NS - 1) / CLK_NS);
	localparam int FLASH_INIT_NS = 1000000; // longest flash init
	localparam int FLASH_INIT_CYC_DEF = FLASH_INIT_NS / CLK_NS;
	localparam int FLASH_BLANK_NS = 1000; // span of the all-ones answer
	localparam logic [7:0] FLASH_BLANK_CYC = 8'(FLASH_BLANK_NS / CLK_NS);
	localparam logic [15:0] FLASH_BLANK_WORD = 16'hFFFF;
	localparam logic [15:0] FLASH_WAIT_WORD = 16'h009B;
	localparam logic [6:0] DIV_SLOW_LAST = 7'h7F; // divide by 128

	////////////////////////////////////////////////////////////////////////
	// register map and fields
	localparam logic [7:0] REG_WDT_CTL = 8'h00; // watchdog_control_register
	localparam logic [7:0] REG_WDT_CNT = 8'h04; // counter, read only
	localparam logic [7:0] REG_SYS_CFG = 8'h08; // system_config_register
	localparam logic [7:0] REG_CMD = 8'h0C; // instruction strobes
	localparam int CTL_PSEL_BIT = 0; // prescale_select_bit
	localparam int SYS_BIDIR_BIT = 3; // bidirectional_reset_enable
	localparam int CMD_SERVICE = 0;
	localparam int CMD_DISABLE = 1;
	localparam int CMD_END_INIT_INSTRUCTION = 2; // end_init_instruction
	localparam int CMD_SWRST = 3; // software_reset_instruction
	localparam int FLG_SW = 0; // software_flag
	localparam int FLG_WDT = 1; // watchdog_overflow_flag
	localparam int FLG_SHW = 2; // short_hardware_flag
	localparam int FLG_LHW = 3; // long_hardware_flag
	localparam int FLG_PON = 4; // power_on_flag

	////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [4:0] {
		ST_RUN = 5'h01, // internal reset released
		ST_ASYNC = 5'h02, // asynchronous or power-on reset
		ST_SYNC = 5'h04, // synchronous hardware reset sequence
		ST_SOFT = 5'h08, // software or watchdog reset sequence
		ST_REL = 5'h10 // waiting for flash or boot release delay
	} wdr_st_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} wdr_bus_req_t;

	typedef struct packed {
		wdr_st_t st;
		logic rin_meta, rin_sync, dis_meta, dis_sync;
		logic boot_meta, boot_sync, fd_meta, fd_sync;
		logic filt; // filtered reset input, high = released
		logic [2:0] fcnt;
		logic [15:0] cnt;
		logic [7:0] fage;
		logic ext_boot, soft_bidir;
		logic wd_en, end_init_instruction, psel, bidir;
		logic [7:0] reload;
		logic [6:0] div;
		logic [15:0] wdt;
		logic [4:0] flags;
		logic [15:0] rdata;
		logic pin_oe, rst_out_n, core_rst_n, io_hiz, p0_pull, fready;
		logic [15:0] fill;
	} wdr_state_t;

	localparam wdr_state_t WDR_RESET = '{
		st: ST_ASYNC, flags: 5'h10, wd_en: 1'b1, io_hiz: 1'b1,
		p0_pull: 1'b1, fill: 16'hFFFF, default: '0};

endpackage

/* File: wdr_board.sv */
`timescale 1ns/100ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// board side of the reset pins: pull-up, push button, discharge network
module wdr_board #(
	parameter int POR_CYC = 20 // stands in for oscillator and pll start-up
) (
	input wire logic clk,
	input wire logic hold_low, // push button pressed
	input wire logic dis_hi, // discharge capacitor charged
	input wire logic dev_oe, // device pulls the reset input pin
	input wire logic dev_out, // value the device drives
	output logic pin_level,
	output logic dis_level
);
	int por_cnt = 0; // cycles since supply came up

	// power-on hold counter, stops once the clock is trusted
	always @(posedge clk) begin
		if (por_cnt < POR_CYC) begin
			por_cnt <= por_cnt + 1;
		end
	end

	// wired pin: pull-up unless the power-on hold, the button or the device pulls it down
	assign pin_level = (por_cnt < POR_CYC || hold_low ||
		(dev_oe && !dev_out)) ? 1'b0 : 1'b1;
	// discharge pin kept low together with reset at power-on
	assign dis_level = (por_cnt < POR_CYC) ? 1'b0 : dis_hi;
endmodule

`default_nettype wire

/* File: watchdog_and_reset_control_test.sv */
`timescale 1ns/100ps
`default_nettype none

module watchdog_and_reset_control_test;
	import wdr_pkg::*;

	// one reset case: kind 0 pin pulse, kind 1 software reset
	typedef struct {
		int kind;
		int len;
		logic dis;
		logic bidir;
		logic oe;
		logic rel;
		logic rst;
		logic [15:0] flags;
	} wdr_row_t;

	wdr_row_t rows [8] = '{
		'{0, 1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000},
		'{0, 2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000},
		'{0, 100, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0008},
		'{0, 700, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 16'h0018},
		'{0, 30, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 16'h0000},
		'{1, 0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 16'h0002},
		'{1, 0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0002},
		'{1, 0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0002}};
	wdr_row_t r;

	logic clk = 1'b0;
	logic resetn = 1'b0;
	wdr_bus_req_t bus_req = '0;
	logic hold_low = 1'b0;
	logic dis_hi = 1'b1;
	logic boot_n = 1'b1; // internal boot first
	logic flash_done = 1'b0; // flash ready comes from the init counter
	logic [15:0] reg_rdata, flash_fill_word, d;
	logic rin_level, rin_out, rin_oe, dis_level, saw_low;
	logic rst_out_n, core_n, io_hiz, p0_pull, flash_ready;
	int err_total = 0;
	int total_checks = 0;
	int cyc = 0;
	int n, expv;

	// 100 ns clock
	always #50 clk = ~clk;

	wdr_top #(.FLASH_INIT_CYC(50)) u_wdr_top (
		.clk(clk), .resetn(resetn), .bus_req(bus_req),
		.reg_rdata(reg_rdata), .reset_input_pin_n_in(rin_level),
		.reset_input_pin_n_out(rin_out), .reset_input_pin_n_oe(rin_oe),
		.discharge_pin(dis_level), .external_boot_pin_n(boot_n),
		.flash_init_done(flash_done), .reset_output_pin_n(rst_out_n),
		.core_reset_n(core_n), .io_hiz(io_hiz), .port0_pullup(p0_pull),
		.flash_ready(flash_ready), .flash_fill_word(flash_fill_word));

	wdr_board u_wdr_board (
		.clk(clk), .hold_low(hold_low), .dis_hi(dis_hi), .dev_oe(rin_oe),
		.dev_out(rin_out), .pin_level(rin_level), .dis_level(dis_level));

	//////////////////////////////////////////////////////////////////////////
	// helpers
	task check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: saw %h expected %h",
				$time, seen, exp);
		end
	endtask

	task end_of_test();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// one-cycle write strobe
	task wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus_req <= '0;
	endtask

	// one-cycle read strobe, data taken in the following cycle
	task rd(input logic [7:0] a);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus_req <= '0;
		#1 d = reg_rdata;
	endtask

	// bounded wait for the internal reset to reach a level
	task wait_core(input logic lvl, input int lim);
		n = 0;
		while (core_n !== lvl && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			end_of_test();
		end
	end

	// notes any internal reset during a case
	always @(posedge clk) begin
		if (core_n === 1'b0) begin
			saw_low <= 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		#1;
		check({12'h0, rst_out_n, core_n, io_hiz, p0_pull}, 16'h0003);
		check(flash_fill_word, FLASH_BLANK_WORD);
		check(16'(flash_ready), 16'h0000);
		repeat (40) @(posedge clk);
		#1 check(16'(core_n), 16'h0000);
		check(flash_fill_word, FLASH_WAIT_WORD);
		wait_core(1'b1, 100);
		check(16'(core_n), 16'h0001);
		rd(REG_WDT_CTL);
		check(d & 16'h003E, 16'h0020);
		@(posedge clk);
		#1 check(reg_rdata, 16'h0000);
		rd(REG_CMD);
		check(d, 16'h0001);
		wr(REG_CMD, 16'h0002);
		rd(REG_CMD);
		check(d, 16'h0000);
		rd(8'h10);
		check(d, 16'h0000);
		@(posedge clk);
		boot_n <= 1'b0;
		// flash reports ready: the ready output follows three clocks later, two syncs and its register
		flash_done <= 1'b1;
		repeat (3) @(posedge clk);
		#1 check(16'(flash_ready), 16'h0001);
		// reset cases
		foreach (rows[i]) begin
			r = rows[i];
			wr(REG_CMD, 16'h0004);
			rd(REG_WDT_CTL);
			check(d & 16'h003E, 16'h0000);
			check(16'(rst_out_n), 16'h0001);
			@(posedge clk);
			dis_hi <= r.dis;
			if (r.bidir) begin
				wr(REG_SYS_CFG, 16'h0008);
			end
			@(negedge clk);
			saw_low = 1'b0;
			if (r.kind == 0) begin
				@(posedge clk);
				hold_low <= 1'b1;
				repeat (r.len) @(posedge clk);
				hold_low <= 1'b0;
				#1 wait_core(1'b1, 3000);
				if (r.rel) begin
					check(16'(n >= 7 && n <= 14), 16'h0001);
				end
			end else begin
				wr(REG_CMD, 16'h0008);
				repeat (2) @(posedge clk);
				#1 check(16'(rin_oe), 16'(r.oe));
			end
			wait_core(1'b1, 3000);
			check(16'(core_n), 16'h0001);
			check(16'(saw_low), 16'(r.rst));
			rd(REG_WDT_CTL);
			check(d & 16'h003E, r.flags);
			@(posedge clk);
			dis_hi <= 1'b1;
		end
		// watchdog overflow at both prescale settings, internal boot
		boot_n <= 1'b1;
		for (int p = 0; p < 2; p++) begin
			wr(REG_CMD, 16'h0004);
			wr(REG_CMD, 16'h0002);
			rd(REG_CMD);
			check(d, 16'h0003);
			wr(REG_WDT_CTL, 16'hFF00 | 16'(p));
			wr(REG_CMD, 16'h0001);
			rd(REG_WDT_CNT);
			check(d & 16'hFFFC, 16'hFF00);
			n = 2;
			expv = 256 * ((p == 1) ? 128 : 2);
			while (core_n === 1'b1 && n < expv + 100) begin
				@(posedge clk);
				#1;
				n++;
			end
			check(16'(n >= expv - expv / 64 && n <= expv + 8),
				16'h0001);
			check(16'(rst_out_n), 16'h0000);
			wait_core(1'b1, 3000);
			// flash already ready: release right after the soft sequence
			check(16'(n < 530), 16'h0001);
			rd(REG_WDT_CTL);
			check(d & 16'h003E, 16'h0004);
			rd(REG_CMD);
			check(d, 16'h0001);
		end
		end_of_test();
	end
endmodule

`default_nettype wire
